/* File: design/audio_in_ctrl.sv */
// Function
// RULE1 - Fill mode bit 0 picks audio path (0) or software words (1) as FIFO source.
// RULE2 - Manual word comes in four write-only byte lanes, lowest address is bits 7:0.
// RULE3 - FIFO entry count readable as low and high bytes, resets to zero.
// RULE4 - Option bit 4 swaps left and right samples for every input source; the code swaps converter samples only, manual words pass as written.
// RULE5 - Option bit 3 makes converter data skip the trim stage.
// RULE6 - Option bit 1 applies the 64/63 scaling to converter data.
// RULE7 - Option bit 0 selects which converter valid qualifier accepts samples.
// RULE8 - Option bit 2 selects the sign format of converter samples.
// RULE9 - Filter bits 3:0 set the high-pass adjustment parameter.
// RULE10 - Filter bit 4 routes samples around the high-pass stage.
// RULE11 - Filter bit 5 routes samples around the level control stage.
// RULE12 - Filter bit 6 routes samples around the low-pass stage.
// RULE13 - Filter bit 7 enables extra factor-of-two down-sampling.
// RULE14 - Level bit 7 auto/manual; bits 5:0 manual gain; bits 6:0 auto minimum gain.
// RULE15 - Writing the top manual lane pushes the word and raises the count by one.
// RULE16 - Software writes the lower three lanes before the top lane.
//
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module audio_in_ctrl
  import audio_in_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire logic [31:0] adc_data_i,
  input  wire logic        adc_valid_a_i,
  input  wire logic        adc_valid_b_i,
  output logic             adc_ready_o,
  output logic      [31:0] out_data_o,
  output logic             out_valid_o,
  input  wire logic        out_ready_i
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [7:0]       mode;
    logic [7:0]       opt;
    logic [7:0]       mul;
    logic [7:0]       bias;
    logic [7:0]       filt;
    logic [7:0]       lvl_l;
    logic [7:0]       lvl_r;
    logic [23:0]      man;
    logic [1:0][15:0] dc;
    logic [1:0][15:0] prv;
    logic             dec;
    logic [1:0][31:0] mem;
    logic             wp;
    logic             rp;
    logic [1:0]       cnt;
    logic             dph;
    logic             dwr;
    logic [11:0]      didx;
    logic [7:0]       rd;
  } st_t;

  st_t s_ff;
  st_t nxt_s;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Front end of one channel: sign format, trim and 64/63 scaling.
  function automatic logic [15:0] front(input logic [15:0] x,
                                        input logic [7:0]  opt,
                                        input logic [7:0]  mul,
                                        input logic [7:0]  bias);
    logic signed [23:0] t;
    t = 24'(signed'(opt[OPT_SGN_BIT] ? (x ^ SIGN_FLIP) : x));
    if (!opt[OPT_TRIM_BIT]) begin
      t = t + ((t * signed'({16'h0000, mul})) >>> CAL_SHIFT)
            + 24'(signed'(bias));
    end
    if (opt[OPT_SCL_BIT]) begin
      t = t + (t >>> SCL_SHIFT);
    end
    return t[15:0];
  endfunction

  // Gain of one level control channel.
  function automatic logic [6:0] gain_of(input logic [7:0] lvl);
    logic [6:0] g;
    g = {1'b0, lvl[LVL_MAN_MSB:0]};
    if (lvl[LVL_AUTO_BIT]) begin
      g = (lvl[LVL_MIN_MSB:0] > UNITY_GAIN) ? lvl[LVL_MIN_MSB:0] : UNITY_GAIN;
    end
    return g;
  endfunction

  // Read value of a register index.
  function automatic logic [7:0] rd_of(input logic [11:0] idx, input st_t s);
    logic [15:0] c;
    c = {14'h0000, s.cnt};
    case (idx)
      IDX_CNT_HI_A: rd_of = c[15:8];
      IDX_CNT_LO_B: rd_of = c[7:0];
      IDX_CNT_HI_B: rd_of = c[15:8];
      IDX_MODE:     rd_of = s.mode;
      IDX_OPT:      rd_of = s.opt;
      IDX_MUL:      rd_of = s.mul;
      IDX_BIAS:     rd_of = s.bias;
      IDX_FILT:     rd_of = s.filt;
      IDX_LVL_L:    rd_of = s.lvl_l;
      IDX_LVL_R:    rd_of = s.lvl_r;
      default:      rd_of = 8'h00;
    endcase
  endfunction

  // ----------------------------------------
  // Datapath and bus decode
  // ----------------------------------------
  logic             manual;
  logic             full;
  logic             in_acc;
  logic             push_auto;
  logic             push_man;
  logic             pop;
  logic             stall;
  logic             wr_go;
  logic [1:0][15:0] raw;
  logic [1:0][15:0] smp;
  logic [31:0]      word;

  // Source select, flow control and bus stall.
  always_comb begin
    manual = s_ff.mode[MODE_MAN_BIT]; // see RULE1
    full = (s_ff.cnt == FIFO_DEPTH);
    adc_ready_o = !manual && !full; // see RULE1
    in_acc = adc_ready_o &&
             (s_ff.opt[OPT_VSEL_BIT] ? adc_valid_b_i : adc_valid_a_i); // see RULE7
    push_auto = in_acc && (!s_ff.filt[FILT_DDS_BIT] || s_ff.dec); // see RULE13
    stall = s_ff.dph && s_ff.dwr && (s_ff.didx == IDX_MAN3) && manual && full;
    wr_go = s_ff.dph && s_ff.dwr && !stall;
    push_man = wr_go && (s_ff.didx == IDX_MAN3) && manual; // see RULE15
    pop = out_valid_o && out_ready_i;
    hreadyout_o = !stall;
    hresp_o = 1'b0;
    hrdata_o = {24'h000000, s_ff.rd};
    out_valid_o = (s_ff.cnt != 2'h0);
    out_data_o = s_ff.mem[s_ff.rp];
  end

  // Channel samples after swap and front end; slot 1 is left.
  always_comb begin
    raw[1] = s_ff.opt[OPT_SWAP_BIT] ? adc_data_i[15:0] : adc_data_i[31:16]; // see RULE4
    raw[0] = s_ff.opt[OPT_SWAP_BIT] ? adc_data_i[31:16] : adc_data_i[15:0]; // see RULE4
    for (int i = 0; i < 2; i++) begin
      smp[i] = front(raw[i], s_ff.opt, s_ff.mul, s_ff.bias); // see RULE5
    end
  end

  // Next state of the whole block.
  always_comb begin
    logic [15:0] x;
    logic [15:0] y;
    logic [22:0] p;
    logic [11:0] aidx;
    nxt_s = s_ff;
    x = 16'h0000;
    y = 16'h0000;
    p = 23'h000000;
    aidx = haddr_i[ADDR_LSB+11:ADDR_LSB];
    word = 32'h00000000;
    // Filter chain per channel: high-pass, level control, low-pass.
    for (int i = 0; i < 2; i++) begin
      x = smp[i];
      if (!s_ff.filt[FILT_HPF_BIT]) begin // see RULE10
        y = x - s_ff.dc[i];
        if (in_acc) begin
          nxt_s.dc[i] = s_ff.dc[i] +
            16'(signed'(y) >>> s_ff.filt[FILT_K_MSB:0]); // see RULE9
        end
        x = y;
      end
      if (!s_ff.filt[FILT_ALC_BIT]) begin // see RULE11
        p = 23'(signed'(x) * signed'({9'h000, gain_of(i == 1 ? s_ff.lvl_l
                                                              : s_ff.lvl_r)}));
        x = p[GAIN_SHIFT+15:GAIN_SHIFT]; // see RULE14
      end
      if (!s_ff.filt[FILT_LPF_BIT]) begin // see RULE12
        y = 16'((17'(signed'(x)) + 17'(signed'(s_ff.prv[i]))) >>> 1);
        if (in_acc) begin
          nxt_s.prv[i] = x;
        end
        x = y;
      end
      word[i*16 +: 16] = x;
    end
    // Down-sampling phase advances on each accepted sample while filter bit 7 is set, and clears to 0 otherwise.
    if (in_acc) begin
      nxt_s.dec = s_ff.filt[FILT_DDS_BIT] ? !s_ff.dec : 1'b0; // see RULE13
    end
    // Manual word assembly from the low three lanes.
    if (push_man) begin
      word = {hwdata_i[7:0], s_ff.man}; // see RULE2
    end
    // FIFO write side.
    if (push_auto || push_man) begin
      nxt_s.mem[s_ff.wp] = word;
      nxt_s.wp = !s_ff.wp;
    end
    if (pop) begin
      nxt_s.rp = !s_ff.rp;
    end
    nxt_s.cnt = s_ff.cnt + 2'((push_auto || push_man) ? 1 : 0)
                         - 2'(pop ? 1 : 0); // see RULE3
    // Register writes during the data phase.
    if (wr_go) begin
      case (s_ff.didx)
        IDX_MODE:  nxt_s.mode = hwdata_i[7:0];
        IDX_MAN0:  nxt_s.man[7:0] = hwdata_i[7:0]; // see RULE2
        IDX_MAN1:  nxt_s.man[15:8] = hwdata_i[7:0]; // see RULE2
        IDX_MAN2:  nxt_s.man[23:16] = hwdata_i[7:0]; // see RULE2
        IDX_OPT:   nxt_s.opt = hwdata_i[7:0];
        IDX_MUL:   nxt_s.mul = hwdata_i[7:0];
        IDX_BIAS:  nxt_s.bias = hwdata_i[7:0];
        IDX_FILT:  nxt_s.filt = hwdata_i[7:0];
        IDX_LVL_L: nxt_s.lvl_l = hwdata_i[7:0];
        IDX_LVL_R: nxt_s.lvl_r = hwdata_i[7:0];
        default:   nxt_s.mode = s_ff.mode;
      endcase
    end
    // Address phase capture; read data is prepared for the data phase.
    if (!stall) begin
      nxt_s.dph = hsel_i && htrans_i[1] && hready_i;
      nxt_s.dwr = hwrite_i;
      nxt_s.didx = aidx;
      nxt_s.rd = (hsel_i && htrans_i[1] && hready_i && !hwrite_i)
                 ? rd_of(aidx, nxt_s) : 8'h00;
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s_ff <= '0;
      s_ff.mode <= RST_MODE;
      s_ff.opt <= RST_OPT;
      s_ff.mul <= RST_MUL;
      s_ff.bias <= RST_BIAS;
      s_ff.filt <= RST_FILT;
      s_ff.lvl_l <= RST_LVL;
      s_ff.lvl_r <= RST_LVL;
      s_ff.man <= {RST_MAN, RST_MAN, RST_MAN};
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_fill_mode: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE1
    s_ff.mode[MODE_MAN_BIT] |-> !adc_ready_o)
    else $error("Audio samples accepted in manual fill mode.");

  a_manual_push: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE15
    (push_man && !pop) |=> (s_ff.cnt == $past(s_ff.cnt) + 2'h1)
      && (s_ff.mem[$past(s_ff.wp)] == {$past(hwdata_i[7:0]), $past(s_ff.man)}))
    else $error("Manual word not pushed as one entry.");

  a_count_read: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE3
    (hsel_i && htrans_i[1] && hready_i && !hwrite_i
      && haddr_i[ADDR_LSB+11:ADDR_LSB] == IDX_CNT_LO_B && !pop && !push_auto)
    |=> hrdata_o == {30'h00000000, s_ff.cnt})
    else $error("Count read does not match entries held.");

  a_swap_sel: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE4
    s_ff.opt[OPT_SWAP_BIT] |-> raw[1] == adc_data_i[15:0])
    else $error("Channel swap not applied.");

  a_valid_sel: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE7
    (adc_ready_o && s_ff.opt[OPT_VSEL_BIT] && !adc_valid_b_i) |-> !in_acc)
    else $error("Wrong valid qualifier used.");

  a_hpf_bypass: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE10
    (s_ff.filt[FILT_HPF_BIT] && !wr_go) |=> $stable(s_ff.dc))
    else $error("High-pass state moved while bypassed.");

  a_half_rate: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE13
    (in_acc && s_ff.filt[FILT_DDS_BIT] && !s_ff.dec) |-> !push_auto)
    else $error("Sample pushed in dropped down-sampling phase.");

  a_reset_vals: assert property (@(posedge clk_i) // see RULE3
    ($past(srst_i) && !srst_i) |-> (s_ff.opt == RST_OPT && s_ff.filt == RST_FILT && s_ff.cnt == 2'h0))
    else $error("Reset values wrong.");

  a_no_overfill: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE15
    full |=> s_ff.cnt <= FIFO_DEPTH)
    else $error("FIFO count above depth.");

  // Source select, manual word assembly and empty flag.
  a_auto_push: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE1
    (in_acc && !s_ff.filt[FILT_DDS_BIT] && !pop)
    |=> s_ff.cnt == $past(s_ff.cnt) + 2'h1)
    else $error("Accepted sample not pushed at full rate.");

  a_lane_one: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE2
    (wr_go && s_ff.didx == IDX_MAN1)
    |=> s_ff.man[15:8] == $past(hwdata_i[7:0]))
    else $error("Second manual lane not stored.");

  a_lane_top: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE2
    push_man |-> word[31:24] == hwdata_i[7:0])
    else $error("Top manual lane not in bits 31 to 24.");

  a_empty_flag: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE3
    (s_ff.cnt == 2'h0) |-> !out_valid_o)
    else $error("Output valid with no entries held.");

  // Front end of the channels.
  a_trim_skip: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE5
    (s_ff.opt[OPT_TRIM_BIT] && !s_ff.opt[OPT_SGN_BIT] && !s_ff.opt[OPT_SCL_BIT])
    |-> smp[0] == raw[0])
    else $error("Trim applied while skipped.");

  a_scale_on: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE6
    (s_ff.opt[OPT_TRIM_BIT] && !s_ff.opt[OPT_SGN_BIT] && s_ff.opt[OPT_SCL_BIT])
    |-> smp[0] == raw[0] + 16'(signed'(raw[0]) >>> SCL_SHIFT))
    else $error("Scaling option not applied.");

  a_sign_flip: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE8
    (s_ff.opt[OPT_TRIM_BIT] && s_ff.opt[OPT_SGN_BIT] && !s_ff.opt[OPT_SCL_BIT])
    |-> smp[0] == (raw[0] ^ SIGN_FLIP))
    else $error("Sign format not applied.");

  // Filter chain.
  a_all_bypass: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE11
    (s_ff.filt[FILT_HPF_BIT] && s_ff.filt[FILT_ALC_BIT] && s_ff.filt[FILT_LPF_BIT] && !push_man)
    |-> word == {smp[1], smp[0]})
    else $error("Bypassed stages changed the samples.");

  a_lpf_bypass: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE12
    (s_ff.filt[FILT_LPF_BIT] && !wr_go) |=> $stable(s_ff.prv))
    else $error("Low-pass state moved while bypassed.");

  a_hpf_idle: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE9
    !in_acc |=> $stable(s_ff.dc))
    else $error("High-pass state moved without a sample.");

  a_full_rate: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE13
    (in_acc && !s_ff.filt[FILT_DDS_BIT]) |-> push_auto)
    else $error("Sample dropped without down-sampling.");

  // Level control gains.
  a_manual_gain: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE14
    !s_ff.lvl_l[LVL_AUTO_BIT] |-> gain_of(s_ff.lvl_l) == {1'b0, s_ff.lvl_l[LVL_MAN_MSB:0]})
    else $error("Manual gain field not used.");

  a_auto_floor: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE14
    s_ff.lvl_r[LVL_AUTO_BIT] |-> (gain_of(s_ff.lvl_r) >= UNITY_GAIN)
      && (gain_of(s_ff.lvl_r) >= s_ff.lvl_r[LVL_MIN_MSB:0]))
    else $error("Automatic gain below its limit.");

  // Bus stall on a full buffer.
  a_stall_hold: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE15
    (stall && !pop) |=> !hreadyout_o)
    else $error("Stalled manual write released without a pop.");

endmodule
`default_nettype wire

/* File: design/audio_in_pkg.sv */
package audio_in_pkg;
  // Register indices; the byte address is four times the index.
  localparam logic [11:0] IDX_CNT_HI_A = 12'hb25;
  localparam logic [11:0] IDX_CNT_LO_B = 12'hb28;
  localparam logic [11:0] IDX_CNT_HI_B = 12'hb29;
  localparam logic [11:0] IDX_MODE     = 12'hb2c;
  localparam logic [11:0] IDX_MAN0     = 12'hb30;
  localparam logic [11:0] IDX_MAN1     = 12'hb31;
  localparam logic [11:0] IDX_MAN2     = 12'hb32;
  localparam logic [11:0] IDX_MAN3     = 12'hb33;
  localparam logic [11:0] IDX_OPT      = 12'hb35;
  localparam logic [11:0] IDX_MUL      = 12'hb36;
  localparam logic [11:0] IDX_BIAS     = 12'hb37;
  localparam logic [11:0] IDX_FILT     = 12'hb40;
  localparam logic [11:0] IDX_LVL_L    = 12'hb41;
  localparam logic [11:0] IDX_LVL_R    = 12'hb42;
  localparam int          ADDR_LSB     = 2;
  // Reset values.
  localparam logic [7:0]  RST_MODE     = 8'h00;
  localparam logic [7:0]  RST_OPT      = 8'h09;
  localparam logic [7:0]  RST_MUL      = 8'h00;
  localparam logic [7:0]  RST_BIAS     = 8'h00;
  localparam logic [7:0]  RST_FILT     = 8'hfb;
  localparam logic [7:0]  RST_LVL      = 8'h20;
  localparam logic [7:0]  RST_MAN      = 8'h00;
  // Field positions.
  localparam int          MODE_MAN_BIT = 0;
  localparam int          OPT_VSEL_BIT = 0;
  localparam int          OPT_SCL_BIT  = 1;
  localparam int          OPT_SGN_BIT  = 2;
  localparam int          OPT_TRIM_BIT = 3;
  localparam int          OPT_SWAP_BIT = 4;
  localparam int          FILT_K_MSB   = 3;
  localparam int          FILT_HPF_BIT = 4;
  localparam int          FILT_ALC_BIT = 5;
  localparam int          FILT_LPF_BIT = 6;
  localparam int          FILT_DDS_BIT = 7;
  localparam int          LVL_AUTO_BIT = 7;
  localparam int          LVL_MAN_MSB  = 5;
  localparam int          LVL_MIN_MSB  = 6;
  // Arithmetic constants.
  localparam logic [6:0]  UNITY_GAIN   = 7'h20;
  localparam int          GAIN_SHIFT   = 5;
  localparam int          CAL_SHIFT    = 8;
  localparam int          SCL_SHIFT    = 6;
  localparam logic [15:0] SIGN_FLIP    = 16'h8000;
  localparam logic [1:0]  FIFO_DEPTH   = 2'h2;
endpackage

/* File: test/audio_in_ctrl_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module audio_in_ctrl_tb_top
  import audio_in_pkg::*;
;
  logic clk_i = 0, srst_i = 1, hsel = 0, hwrite = 0, va = 0, vb = 0, ordy = 0;
  logic [31:0] haddr = 0, hwdata = 0, adata = 0, hrdata_o, out_data_o;
  logic [1:0] htrans = 0;
  logic hreadyout_o, hresp_o, adc_ready_o, out_valid_o;
  int err_count = 0, total_checks = 0;

  audio_in_ctrl audio_in_ctrl_i (.clk_i(clk_i), .srst_i(srst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hreadyout_o),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .adc_data_i(adata),
    .adc_valid_a_i(va), .adc_valid_b_i(vb), .adc_ready_o(adc_ready_o), .out_data_o(out_data_o),
    .out_valid_o(out_valid_o), .out_ready_i(ordy));

  // ----------------------------------------
  // Clock, checks and closing
  // ----------------------------------------
  // The clock toggles every half period of 20 ns.
  always #20 clk_i = ~clk_i;

  // Compares one value and counts the result.
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Expected word with the channel halves exchanged.
  function automatic logic [31:0] swp(input logic [31:0] d);
    return {d[15:0], d[31:16]};
  endfunction

  // Expected front end of one channel: sign flip, trim and 64/63 scaling.
  function automatic logic [15:0] fr(input logic [15:0] x, input logic [7:0] o, input logic [7:0] m,
                                     input logic [7:0] b);
    int t;
    t = $signed(o[2] ? x ^ 16'h8000 : x);
    if (!o[3]) t = t + ((t * int'(m)) >>> 8) + $signed(b);
    if (o[1]) t = t + (t >>> 6);
    return t[15:0];
  endfunction

  // Expected gain: manual field, or the auto limit but never below unity.
  function automatic int gn(input logic [7:0] l);
    return l[7] ? ((l[6:0] > 7'h20) ? l[6:0] : 7'h20) : l[5:0];
  endfunction

  // Expected word with front end and level control, other stages bypassed.
  function automatic logic [31:0] ew(input logic [31:0] d, input logic [7:0] o, input logic [7:0] m,
                                     input logic [7:0] b, input logic [7:0] ll, input logic [7:0] lr);
    int l;
    int r;
    l = (int'($signed(fr(d[31:16], o, m, b))) * gn(ll)) >>> 5;
    r = (int'($signed(fr(d[15:0], o, m, b))) * gn(lr)) >>> 5;
    return {l[15:0], r[15:0]};
  endfunction

  // ----------------------------------------
  // Bus and stream tasks
  // ----------------------------------------
  // One single AHB transfer; each phase is held until ready is sampled high at a rising edge.
  task automatic ahb(input logic w, input logic [11:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {18'h0, idx, 2'h0};
    hwrite <= w;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
  endtask

  // Reads a register and compares it.
  task automatic rdc(input logic [11:0] idx, input logic [7:0] exp);
    logic [31:0] rd;
    ahb(1'b0, idx, 32'h0, rd);
    chk($sformatf("reg %h", idx), rd, {24'h0, exp});
    chk("hresp", hresp_o, 32'h0);
  endtask

  // Writes one register byte.
  task automatic wr(input logic [11:0] idx, input logic [7:0] v);
    logic [31:0] rd;
    ahb(1'b1, idx, {24'h0, v}, rd);
  endtask

  // Offers one sample on qualifier b, with a random level on qualifier a, until it is taken.
  task automatic push(input logic [31:0] d);
    adata <= d;
    vb <= 1'b1;
    va <= 1'($urandom);
    do @(posedge clk_i); while (adc_ready_o !== 1'b1);
    vb <= 1'b0;
    adata <= ~d;
    @(posedge clk_i);
  endtask

  // Pops the head word and checks it at the edge where it is taken.
  task automatic pop(input logic [31:0] exp);
    ordy <= 1'b1;
    @(posedge clk_i);
    chk("out valid", out_valid_o, 32'h1);
    chk("out data", out_data_o, exp);
    ordy <= 1'b0;
    @(posedge clk_i);
  endtask

  // Sends a manual word lane by lane, top lane last.
  task automatic man(input logic [31:0] w);
    for (int i = 0; i < 4; i++) wr(IDX_MAN0 + 12'(i), w[8*i+:8]);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  // Watchdog far beyond the expected run length.
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    complete_run();
  end

  initial begin
    logic [11:0] ri[12];
    logic [7:0] rv[12];
    logic [31:0] d[4];
    logic [7:0] v;
    ri = '{IDX_MODE, IDX_OPT, IDX_MUL, IDX_BIAS, IDX_FILT, IDX_LVL_L, IDX_LVL_R,
           IDX_CNT_LO_B, IDX_CNT_HI_B, IDX_CNT_HI_A, IDX_MAN0, 12'hb26};
    rv = '{RST_MODE, RST_OPT, RST_MUL, RST_BIAS, RST_FILT, RST_LVL, RST_LVL,
           8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    void'($urandom(32'h1e2f));
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    // Reset values, a write-only lane and a reserved place all read as tabled.
    for (int i = 0; i < 12; i++) rdc(ri[i], rv[i]);
    // Read-write registers other than mode and option keep random values; count ignores writes.
    for (int i = 2; i < 7; i++) begin
      v = 8'($urandom);
      wr(ri[i], v);
      rdc(ri[i], v);
    end
    wr(IDX_FILT, RST_FILT);
    wr(IDX_CNT_LO_B, 8'hff);
    rdc(IDX_CNT_LO_B, 8'h00);
    // Halved rate: of four samples only the second and fourth are kept.
    for (int i = 0; i < 4; i++) d[i] = $urandom;
    for (int i = 0; i < 4; i++) push(d[i]);
    @(posedge clk_i);
    chk("adc ready full", adc_ready_o, 32'h0);
    rdc(IDX_CNT_LO_B, 8'h02);
    pop(d[1]);
    pop(d[3]);
    // Full rate with all stages bypassed and the channels swapped.
    wr(IDX_FILT, 8'h7b);
    wr(IDX_OPT, 8'h19);
    push(d[0]);
    push(d[2]);
    pop(swp(d[0]));
    pop(swp(d[2]));
    // Qualifier a selected: a sample on qualifier b alone is not taken.
    va <= 1'b0;
    wr(IDX_OPT, 8'h08);
    vb <= 1'b1;
    repeat (3) @(posedge clk_i);
    vb <= 1'b0;
    @(posedge clk_i);
    chk("out valid idle", out_valid_o, 32'h0);
    wr(IDX_OPT, RST_OPT);
    push(d[1]);
    pop(d[1]);
    // Front end and level control on random settings, other stages bypassed.
    v = 8'h01 | (8'($urandom) & 8'h0e);
    rv[0] = 8'($urandom);
    rv[1] = 8'($urandom);
    rv[2] = 8'($urandom) & 8'h3f;
    rv[3] = 8'h80 | 8'($urandom);
    wr(IDX_OPT, v);
    wr(IDX_MUL, rv[0]);
    wr(IDX_BIAS, rv[1]);
    wr(IDX_LVL_L, rv[2]);
    wr(IDX_LVL_R, rv[3]);
    wr(IDX_FILT, 8'h5b);
    push(d[2]);
    pop(ew(d[2], v, rv[0], rv[1], rv[2], rv[3]));
    // Manual fill: path refused, words pushed whole, a third write stalls.
    wr(IDX_MODE, 8'h01);
    @(posedge clk_i);
    chk("adc ready manual", adc_ready_o, 32'h0);
    man(d[0]);
    man(d[1]);
    rdc(IDX_CNT_LO_B, 8'h02);
    fork
      man(d[2]);
      begin
        repeat (12) @(posedge clk_i);
        chk("bus stalled", hreadyout_o, 32'h0);
        pop(d[0]);
      end
    join
    pop(d[1]);
    pop(d[2]);
    rdc(IDX_CNT_LO_B, 8'h00);
    complete_run();
  end
endmodule
`default_nettype wire
